// ---- design/flash_cmd_defs.svh ----
// constants for the serial flash command engine
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

// ****************************************
// opcodes
// ****************************************
`define OP_WRITE_ENABLE 8'h06
`define OP_VOL_WRITE_ENABLE 8'h50
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_STATUS_LO 8'h05
`define OP_READ_STATUS_HI 8'h35
`define OP_WRITE_STATUS 8'h01
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_DUAL_OUT_READ 8'h3b
`define OP_QUAD_OUT_READ 8'h6b
`define OP_DUAL_IO_READ 8'hbb
`define OP_QUAD_IO_READ 8'heb

// ****************************************
// phase lengths in serial clocks
// ****************************************
`define OPCODE_CLOCKS 5'h08
`define ADDR_CLOCKS_SINGLE 5'h18
`define ADDR_CLOCKS_DUAL 5'h0c
`define ADDR_CLOCKS_QUAD 5'h06
`define MODE_CLOCKS_DUAL 5'h04
`define MODE_CLOCKS_QUAD 5'h02
`define DUMMY_CLOCKS_FAST 5'h08
`define DUMMY_CLOCKS_QUAD_IO 5'h04
`define SR_IN_BYTE 5'h08
`define SR_IN_WORD 5'h10
`define SR_IN_LIMIT 5'h11

// ****************************************
// status word layout
// ****************************************
`define SR_RESET 16'h0000
`define SR_WRITE_MASK 16'h7ffc
`define SR_SHORT_CLEAR_MASK 16'h4300
`define SR_QE_BIT 9
`define CONT_MODE_KEY 2'b10

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 25
`define STATUS_WRITE_DURATION_NS 10000000
`define STATUS_WRITE_CYCLES ((`STATUS_WRITE_DURATION_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define VOLATILE_UPDATE_TIME_NS 50
`define VOLATILE_UPDATE_CYCLES (`VOLATILE_UPDATE_TIME_NS / `CLK_PERIOD_NS)

// ****************************************
// read buffer
// ****************************************
`define FIFO_WIDTH 8
`define FIFO_DEPTH 8

`endif

// ---- design/flash_cmd_pkg.sv ----
// types shared by the serial flash command engine
package flash_cmd_pkg;

    typedef enum logic [2:0] {
        LANE_1 = 3'b001,
        LANE_2 = 3'b010,
        LANE_4 = 3'b100
    } lane_t;

    typedef enum logic [7:0] {
        ST_OPCODE = 8'h01,
        ST_ADDR = 8'h02,
        ST_MODE = 8'h04,
        ST_DUMMY = 8'h08,
        ST_DATA = 8'h10,
        ST_SR_OUT = 8'h20,
        ST_SR_IN = 8'h40,
        ST_IGNORE = 8'h80
    } phase_t;

    typedef struct packed {
        logic suspend;
        logic protect_complement;
        logic [3:0] lock_bits;
        logic quad_pins_enable;
        logic status_protect_upper;
        logic status_protect_lower;
        logic sector_protect;
        logic top_bottom;
        logic [2:0] block_protect;
        logic write_enable_latch;
        logic busy;
    } status_t;

    typedef struct packed {
        logic en;
        logic [23:0] addr;
    } mem_req_t;

endpackage

// ---- design/read_fifo.sv ----
// synchronous fifo with valid/ready on both sides
module read_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || clear) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

// ---- design/flash_cmd_engine.sv ----
// serial flash command engine: status write completion and read commands
`include "flash_cmd_defs.svh"

module flash_cmd_engine
    import flash_cmd_pkg::*;
#(
    parameter int unsigned STATUS_WRITE_CYCLES = `STATUS_WRITE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_n,
    input wire logic array_busy,
    output mem_req_t mem_req,
    input wire logic [7:0] mem_rd_data,
    output status_t status_word
);

    // ****************************************
    // pin edge detection
    // ****************************************
    logic cs_prev_reg;
    logic sclk_prev_reg;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cs_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end else begin
            cs_prev_reg <= cs_n;
            sclk_prev_reg <= sclk;
        end
    end

    assign cs_rise = cs_n && !cs_prev_reg;
    assign sclk_rise = !cs_n && sclk && !sclk_prev_reg;
    assign sclk_fall = !cs_n && !sclk && sclk_prev_reg;

    // ****************************************
    // command state
    // ****************************************
    phase_t phase_reg;
    lane_t lanes_reg;
    logic [7:0] cmd_reg;
    logic cmd_done_reg;
    logic cont_reg;
    logic sr_sel_reg;
    logic [4:0] cnt_reg;
    logic [23:0] rx_reg;
    logic [23:0] rx_next;
    logic [4:0] phase_len;
    logic phase_last;
    logic addr_load;
    logic busy;
    logic qe;
    logic [15:0] sr_reg;
    logic nv_busy_reg;

    assign busy = nv_busy_reg || array_busy;
    assign qe = sr_reg[`SR_QE_BIT];

    // sample one, two or four lanes per rising edge
    always_comb begin
        unique case (lanes_reg)
            LANE_1: rx_next = {rx_reg[22:0], io_in[0]};
            LANE_2: rx_next = {rx_reg[21:0], io_in[1:0]};
            LANE_4: rx_next = {rx_reg[19:0], io_in[3:0]};
        endcase
    end

    always_comb begin
        if (phase_reg == ST_ADDR) begin
            if (lanes_reg == LANE_4) begin
                phase_len = `ADDR_CLOCKS_QUAD;
            end else if (lanes_reg == LANE_2) begin
                phase_len = `ADDR_CLOCKS_DUAL;
            end else begin
                phase_len = `ADDR_CLOCKS_SINGLE;
            end
        end else if (phase_reg == ST_MODE) begin
            phase_len = (lanes_reg == LANE_4) ? `MODE_CLOCKS_QUAD : `MODE_CLOCKS_DUAL;
        end else if (phase_reg == ST_DUMMY) begin
            phase_len = (cmd_reg == `OP_QUAD_IO_READ) ? `DUMMY_CLOCKS_QUAD_IO : `DUMMY_CLOCKS_FAST;
        end else begin
            phase_len = `OPCODE_CLOCKS;
        end
    end

    assign phase_last = ((cnt_reg + 5'h01) == phase_len);
    assign addr_load = sclk_rise && phase_reg == ST_ADDR && phase_last;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_reg <= ST_OPCODE;
            lanes_reg <= LANE_1;
            cmd_reg <= 8'h00;
            cmd_done_reg <= 1'b0;
            cont_reg <= 1'b0;
            sr_sel_reg <= 1'b0;
            cnt_reg <= 5'h00;
            rx_reg <= 24'h000000;
        end else if (cs_n) begin
            // a kept mode key opens the next frame straight at the address
            cnt_reg <= 5'h00;
            cmd_done_reg <= 1'b0;
            phase_reg <= cont_reg ? ST_ADDR : ST_OPCODE;
            if (!cont_reg) begin
                lanes_reg <= LANE_1;
            end
        end else if (sclk_rise) begin
            rx_reg <= rx_next;
            if (phase_reg == ST_SR_IN) begin
                if (cnt_reg != `SR_IN_LIMIT) begin
                    cnt_reg <= cnt_reg + 5'h01;
                end
            end else if (phase_last) begin
                cnt_reg <= 5'h00;
            end else begin
                cnt_reg <= cnt_reg + 5'h01;
            end
            unique case (phase_reg)
                ST_OPCODE: begin
                    if (phase_last) begin
                        cmd_reg <= rx_next[7:0];
                        cmd_done_reg <= 1'b1;
                        phase_reg <= ST_IGNORE;
                        unique case (rx_next[7:0])
                            `OP_READ_STATUS_LO: begin
                                phase_reg <= ST_SR_OUT;
                                sr_sel_reg <= 1'b0;
                            end
                            `OP_READ_STATUS_HI: begin
                                phase_reg <= ST_SR_OUT;
                                sr_sel_reg <= 1'b1;
                            end
                            `OP_WRITE_STATUS: begin
                                if (!busy) begin
                                    phase_reg <= ST_SR_IN;
                                end
                            end
                            `OP_READ, `OP_FAST_READ, `OP_DUAL_OUT_READ: begin
                                if (!busy) begin
                                    phase_reg <= ST_ADDR;
                                end
                            end
                            `OP_QUAD_OUT_READ: begin
                                if (!busy && qe) begin
                                    phase_reg <= ST_ADDR;
                                end
                            end
                            `OP_DUAL_IO_READ: begin
                                if (!busy) begin
                                    phase_reg <= ST_ADDR;
                                    lanes_reg <= LANE_2;
                                end
                            end
                            `OP_QUAD_IO_READ: begin
                                if (!busy && qe) begin
                                    phase_reg <= ST_ADDR;
                                    lanes_reg <= LANE_4;
                                end
                            end
                            default: begin
                                phase_reg <= ST_IGNORE;
                            end
                        endcase
                    end
                end
                ST_ADDR: begin
                    if (phase_last) begin
                        if (cmd_reg == `OP_DUAL_IO_READ || cmd_reg == `OP_QUAD_IO_READ) begin
                            phase_reg <= ST_MODE;
                        end else if (cmd_reg == `OP_READ) begin
                            phase_reg <= ST_DATA;
                        end else begin
                            phase_reg <= ST_DUMMY;
                        end
                    end
                end
                ST_MODE: begin
                    if (phase_last) begin
                        // only bits 5:4 of the mode byte matter
                        cont_reg <= (rx_next[5:4] == `CONT_MODE_KEY);
                        phase_reg <= (lanes_reg == LANE_4) ? ST_DUMMY : ST_DATA;
                    end
                end
                ST_DUMMY: begin
                    if (phase_last) begin
                        phase_reg <= ST_DATA;
                        if (cmd_reg == `OP_DUAL_OUT_READ) begin
                            lanes_reg <= LANE_2;
                        end else if (cmd_reg == `OP_QUAD_OUT_READ) begin
                            lanes_reg <= LANE_4;
                        end
                    end
                end
                ST_DATA, ST_SR_OUT, ST_SR_IN, ST_IGNORE: begin
                end
            endcase
        end
    end

    // ****************************************
    // status word and write cycles
    // ****************************************
    logic wel_reg;
    logic vol_en_reg;
    logic vol_pend_reg;
    logic [31:0] timer_reg;
    logic [15:0] sr_pending_reg;
    logic [15:0] sr_candidate;
    logic [15:0] sr_merged;
    logic sr_len_ok;

    assign sr_len_ok = (cnt_reg == `SR_IN_BYTE) || (cnt_reg == `SR_IN_WORD);
    // the first data byte always lands in the low half
    assign sr_candidate = (cnt_reg == `SR_IN_BYTE) ?
        ({sr_reg[15:8], rx_reg[7:0]} & ~`SR_SHORT_CLEAR_MASK) : {rx_reg[7:0], rx_reg[15:8]};
    assign sr_merged = (sr_reg & ~`SR_WRITE_MASK) | (sr_candidate & `SR_WRITE_MASK);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sr_reg <= `SR_RESET;
            sr_pending_reg <= `SR_RESET;
            wel_reg <= 1'b0;
            vol_en_reg <= 1'b0;
            nv_busy_reg <= 1'b0;
            vol_pend_reg <= 1'b0;
            timer_reg <= 32'h00000000;
        end else begin
            if (nv_busy_reg) begin
                if (timer_reg == STATUS_WRITE_CYCLES - 1) begin
                    sr_reg <= sr_pending_reg;
                    nv_busy_reg <= 1'b0;
                    wel_reg <= 1'b0;
                end else begin
                    timer_reg <= timer_reg + 32'h00000001;
                end
            end else if (vol_pend_reg) begin
                if (timer_reg == `VOLATILE_UPDATE_CYCLES - 1) begin
                    sr_reg <= sr_pending_reg;
                    vol_pend_reg <= 1'b0;
                end else begin
                    timer_reg <= timer_reg + 32'h00000001;
                end
            end
            if (cs_rise && cmd_done_reg && !busy && !vol_pend_reg) begin
                if (cmd_reg == `OP_WRITE_ENABLE) begin
                    wel_reg <= 1'b1;
                end else if (cmd_reg == `OP_WRITE_DISABLE) begin
                    wel_reg <= 1'b0;
                    vol_en_reg <= 1'b0;
                end else if (cmd_reg == `OP_VOL_WRITE_ENABLE) begin
                    vol_en_reg <= 1'b1;
                end else if (cmd_reg == `OP_WRITE_STATUS && sr_len_ok) begin
                    sr_pending_reg <= sr_merged;
                    timer_reg <= 32'h00000000;
                    if (wel_reg) begin
                        nv_busy_reg <= 1'b1;
                    end else if (vol_en_reg) begin
                        vol_pend_reg <= 1'b1;
                        vol_en_reg <= 1'b0;
                    end
                end
            end
        end
    end

    // busy and latch overlay the stored word; the view lags one cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_word <= status_t'(`SR_RESET);
        end else begin
            status_word <= status_t'({sr_reg[15:2], wel_reg, busy});
        end
    end

    // ****************************************
    // array prefetch into the read buffer
    // ****************************************
    logic fetch_active_reg;
    logic fetch_pending_reg;
    logic fetch_ret_reg;
    logic [23:0] fetch_addr_reg;
    logic fifo_clear;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [7:0] fifo_out_data;

    assign fifo_clear = cs_n || addr_load;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fetch_active_reg <= 1'b0;
            fetch_pending_reg <= 1'b0;
            fetch_ret_reg <= 1'b0;
            fetch_addr_reg <= 24'h000000;
            mem_req <= '0;
        end else begin
            fetch_pending_reg <= 1'b0;
            fetch_ret_reg <= fetch_pending_reg;
            mem_req.en <= 1'b0;
            if (cs_n) begin
                fetch_active_reg <= 1'b0;
            end else if (addr_load) begin
                fetch_active_reg <= 1'b1;
                fetch_addr_reg <= rx_next;
            end else if (fetch_active_reg && !fetch_pending_reg && !fetch_ret_reg && fifo_in_ready) begin
                // the answer lands a cycle after the request; one in flight keeps a slot free
                mem_req.en <= 1'b1;
                mem_req.addr <= fetch_addr_reg;
                fetch_addr_reg <= fetch_addr_reg + 24'h000001;
                fetch_pending_reg <= 1'b1;
            end
        end
    end

    read_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) u_read_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clear(fifo_clear),
        .in_valid(fetch_ret_reg && fetch_active_reg),
        .in_ready(fifo_in_ready),
        .in_data(mem_rd_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ****************************************
    // output shifter
    // ****************************************
    logic [7:0] out_byte_reg;
    logic [2:0] out_left_reg;
    logic [7:0] tx_byte;
    logic [7:0] new_byte;
    logic out_phase;

    assign out_phase = (phase_reg == ST_DATA) || (phase_reg == ST_SR_OUT);
    assign fifo_pop = sclk_fall && phase_reg == ST_DATA && out_left_reg == 3'h0;
    // an empty buffer reads as all ones: the serial clock must leave time to prefetch
    assign new_byte = (phase_reg == ST_SR_OUT) ?
        (sr_sel_reg ? status_word[15:8] : status_word[7:0]) :
        (fifo_out_valid ? fifo_out_data : 8'hff);
    assign tx_byte = (out_left_reg == 3'h0) ? new_byte : out_byte_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            io_out <= 4'h0;
            io_oe_n <= 4'hf;
            out_byte_reg <= 8'h00;
            out_left_reg <= 3'h0;
        end else if (cs_n) begin
            io_oe_n <= 4'hf;
            out_left_reg <= 3'h0;
        end else if (sclk_fall && out_phase) begin
            if (phase_reg == ST_SR_OUT || lanes_reg == LANE_1) begin
                io_out <= {2'b00, tx_byte[7], 1'b0};
                io_oe_n <= 4'hd;
                out_byte_reg <= {tx_byte[6:0], 1'b0};
                out_left_reg <= (out_left_reg == 3'h0) ? 3'h7 : out_left_reg - 3'h1;
            end else if (lanes_reg == LANE_2) begin
                io_out <= {2'b00, tx_byte[7:6]};
                io_oe_n <= 4'hc;
                out_byte_reg <= {tx_byte[5:0], 2'b00};
                out_left_reg <= (out_left_reg == 3'h0) ? 3'h3 : out_left_reg - 3'h1;
            end else begin
                io_out <= tx_byte[7:4];
                io_oe_n <= 4'h0;
                out_byte_reg <= {tx_byte[3:0], 4'h0};
                out_left_reg <= (out_left_reg == 3'h0) ? 3'h1 : out_left_reg - 3'h1;
            end
        end else if (!out_phase) begin
            io_oe_n <= 4'hf;
        end
    end

endmodule

// ---- tb/flash_cmd_engine_asserts.sv ----
// concurrent checks on the flash command engine ports
module flash_cmd_engine_asserts
    import flash_cmd_pkg::*;
#(
    parameter int unsigned STATUS_WRITE_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe_n,
    input wire logic array_busy,
    input wire mem_req_t mem_req,
    input wire logic [7:0] mem_rd_data,
    input wire status_t status_word
);
    // ****************************************
    // port checks
    // ****************************************
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    int unsigned busy_cnt_reg;
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !status_word.busy) busy_cnt_reg <= 0;
        else busy_cnt_reg <= busy_cnt_reg + 1;
    end
    a_reset_status: assert property (disable iff (1'b0) sys_rst |=> status_word == 16'h0000 && io_oe_n == 4'hf)
        else $error("status or pins not cleared by reset");
    a_pins_idle: assert property (cs_n && $past(cs_n) |-> io_oe_n == 4'hf)
        else $error("pins driven while deselected");
    a_lane_shape: assert property (io_oe_n inside {4'hf, 4'hd, 4'hc, 4'h0})
        else $error("unexpected pin drive pattern");
    a_drive_on_fall: assert property (!$stable(io_out) && io_oe_n != 4'hf |-> !$past(sclk) && $past(sclk, 2))
        else $error("output changed away from a falling edge");
    a_quad_gated: assert property (!status_word.quad_pins_enable && !$past(status_word.quad_pins_enable)
        |-> io_oe_n != 4'h0)
        else $error("quad output without quad enable");
    a_busy_no_read: assert property (status_word.busy && $past(status_word.busy) |-> !mem_req.en)
        else $error("array read while busy");
    a_busy_length: assert property ($fell(status_word.busy) && $past(status_word.write_enable_latch)
        |-> busy_cnt_reg >= STATUS_WRITE_CYCLES - 1)
        else $error("status write cycle too short");
    a_latch_cleared: assert property ($fell(status_word.busy) |-> ##[0:1] !status_word.write_enable_latch)
        else $error("write enable latch kept after write");
    a_busy_start: assert property ($rose(status_word.busy) && !$past(array_busy)
        |-> $past(cs_n) && $past(status_word.write_enable_latch))
        else $error("busy without deselect or latch");
    a_one_request: assert property (mem_req.en |=> !mem_req.en)
        else $error("back to back array requests");
    c_quad_out: cover property (io_oe_n == 4'h0);
    c_dual_out: cover property (io_oe_n == 4'hc);
    c_busy: cover property ($rose(status_word.busy));
endmodule

// ---- tb/spi_host_model.sv ----
// spi host model that drives frames into the flash command engine
module spi_host_model (
    input wire logic ref_clk,
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // frame driver
    // ****************************************
    logic [3:0] hd = 4'h0;
    logic he = 1'b0;
    logic tog = 1'b0;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
    end
    // no pull resistors: a line nobody drives toggles so stale values cannot pass
    always @(posedge ref_clk) tog <= ~tog;
    assign io_in = (~io_oe_n & io_out) | (io_oe_n & (he ? hd : {4{tog}}));
    task automatic start();
        @(posedge ref_clk);
        cs_n <= 1'b0;
    endtask
    task automatic stop();
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'b1;
        he <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    // four cycles per sclk level keeps the fetch window above the minimum
    task automatic xfer(input logic [31:0] v, input int n, input int w, input bit drv, output logic [31:0] r);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        r = 32'h0;
        for (int k = 0; k < n / w; k++) begin
            he <= drv;
            if (drv) hd <= 4'(v >> (n - w * k - w)) & m;
            repeat (4) @(posedge ref_clk);
            sclk <= 1'b1;
            @(posedge ref_clk);
            r = (r << w) | ((w == 1) ? 32'(io_in[1]) : 32'(io_in & m));
            repeat (3) @(posedge ref_clk);
            sclk <= 1'b0;
        end
    endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the serial flash command engine
module testbench
    import flash_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // bench
    // ****************************************
    localparam int unsigned SW_CYCLES = 1500;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic array_busy = 1'b0;
    logic cs_n;
    logic sclk;
    logic [3:0] io_in;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
    logic [7:0] mem_rd_data = 8'h00;
    mem_req_t mem_req;
    status_t status_word;
    int bad_count = 0;
    int total_checks = 0;
    int pulses = 0;
    int cycles = 0;
    logic [15:0] sr;
    logic [31:0] r;
    // op, skip opcode, address lanes, data lanes, dummies, mode byte
    int rows [9][6] = '{'{'h03, 0, 1, 1, 0, 0}, '{'h0b, 0, 1, 1, 8, 0}, '{'h3b, 0, 1, 2, 8, 0},
        '{'hbb, 0, 2, 2, 0, 'h20}, '{'hbb, 1, 2, 2, 0, 0}, '{'h6b, 0, 1, 4, 8, 0},
        '{'heb, 0, 4, 4, 4, 'h20}, '{'heb, 1, 4, 4, 4, 0}, '{'heb, 0, 4, 4, 4, 0}};
    always #12.5 ref_clk = ~ref_clk;
    flash_cmd_engine #(.STATUS_WRITE_CYCLES(SW_CYCLES)) i_flash_cmd_engine (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .array_busy(array_busy),
        .mem_req(mem_req), .mem_rd_data(mem_rd_data), .status_word(status_word));
    spi_host_model i_spi_host_model (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
        .io_oe_n(io_oe_n));
    function automatic logic [7:0] mem_f(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    always @(posedge ref_clk) begin
        cycles++;
        if (mem_req.en === 1'b1) begin
            mem_rd_data <= mem_f(mem_req.addr);
            pulses++;
        end
        if (cycles == 60000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [31:0] v, input int n, input bit drv);
        i_spi_host_model.start();
        i_spi_host_model.xfer(op, 8, 1, 1, r);
        if (n > 0) i_spi_host_model.xfer(v, n, 1, drv, r);
        i_spi_host_model.stop();
    endtask
    task automatic swr(input logic [7:0] en, input logic [15:0] v, input int n);
        if (en != 8'h00) cmd(en, 0, 0, 1'b1);
        cmd(8'h01, (n == 16) ? {v[7:0], v[15:8]} : v, n, 1'b1);
    endtask
    task automatic rd(input int row [6], input bit ok);
        logic [23:0] a;
        int c;
        a = 24'($urandom);
        c = pulses;
        i_spi_host_model.start();
        if (row[1] == 0) i_spi_host_model.xfer(row[0], 8, 1, 1, r);
        i_spi_host_model.xfer(a, 24, row[2], 1, r);
        if (row[2] > 1) i_spi_host_model.xfer(row[5], 8, row[2], 1, r);
        if (row[4] > 0) i_spi_host_model.xfer(0, row[4], 1, 0, r);
        for (int i = 0; i < 2; i++) begin
            i_spi_host_model.xfer(0, 8, row[3], 0, r);
            if (ok) check("read_data", r[7:0], mem_f(a + 24'(i)));
        end
        i_spi_host_model.stop();
        check("read_taken", 16'(pulses != c), 16'(ok));
    endtask
    initial begin
        void'($urandom(32'ha6f9));
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("status_reset", status_word, 16'h0000);
        swr(8'h00, 16'h7ffc, 16);
        check("status_unlatched", status_word, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 7 + 2 * p; k++) rd(rows[k], k < 5 || p == 1);
            sr = 16'(($urandom & 16'h7ffc) | 16'h0200);
            swr(8'h50, sr, 16);
            check("status_volatile", status_word, sr);
        end
        array_busy <= 1'b1;
        rd(rows[0], 1'b0);
        array_busy <= 1'b0;
        swr(8'h50, 16'h00fc, 8);
        sr = (sr & 16'h3c00) | 16'h00fc;
        check("status_short", status_word, sr);
        swr(8'h50, 16'h0fff, 12);
        check("status_discard", status_word, sr);
        sr = 16'($urandom) & 16'h7ffc;
        swr(8'h06, sr, 16);
        check("busy_set", status_word.busy, 1'b1);
        cmd(8'h05, 0, 8, 1'b0);
        check("status_read_busy", r[0], 1'b1);
        rd(rows[0], 1'b0);
        for (int i = 0; i < 2 * SW_CYCLES && status_word.busy !== 1'b0; i++) @(posedge ref_clk);
        check("status_nonvolatile", status_word, sr);
        cmd(8'h35, 0, 8, 1'b0);
        check("status_read_hi", r[7:0], sr[15:8]);
        rd(rows[0], 1'b1);
        stop_test();
    end
endmodule
bind flash_cmd_engine flash_cmd_engine_asserts #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) i_asserts (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n), .array_busy(array_busy), .mem_req(mem_req), .mem_rd_data(mem_rd_data),
    .status_word(status_word));
